/* File: csq_pkg.sv */
// ============================================================
// Shared constants for the conditional search qualifier
// ============================================================
package csq_pkg;
    // ROM function command bytes
    localparam logic [7:0] CMD_READ = 8'h33;
    localparam logic [7:0] CMD_MATCH = 8'h55;
    localparam logic [7:0] CMD_SKIP = 8'hCC;
    localparam logic [7:0] CMD_SEARCH = 8'hF0;
    localparam logic [7:0] CMD_COND = 8'hEC;

    // Status memory locations
    localparam logic [2:0] OFS_DEFAULT = 3'h6;
    localparam logic [2:0] OFS_COND = 3'h7;

    // Erased one-time-programmable byte reads all ones
    localparam logic [7:0] DEFAULT_RESET = 8'hFF;
    localparam logic [4:0] COND_RESET = 5'h1F;

    // Field positions in the condition byte
    localparam int POL_BIT = 0;
    localparam int SRC_LO = 1;
    localparam int SRC_HI = 2;
    localparam int CH_LO = 3;
    localparam int CH_HI = 4;
    localparam int COND_W = 5;

    // Source select codes
    localparam logic [1:0] SRC_HIDDEN = 2'h0;
    localparam logic [1:0] SRC_LATCH = 2'h1;
    localparam logic [1:0] SRC_FLOP = 2'h2;
    localparam logic [1:0] SRC_PIN = 2'h3;

    // Channel select codes
    localparam logic [1:0] CH_NONE = 2'h0;

    // First channel control byte: latch clear bit
    localparam int CTRL1_CLR_BIT = 7;

    // Channel information byte layout
    localparam int INFO_SUPPLY = 7;
    localparam int INFO_HAS_B = 6;
    localparam int INFO_LATCH_B = 5;
    localparam int INFO_LATCH_A = 4;
    localparam int INFO_PIN_B = 3;
    localparam int INFO_PIN_A = 2;
    localparam int INFO_FLOP_B = 1;
    localparam int INFO_FLOP_A = 0;

    // Link-level state of this slave
    typedef enum logic [2:0] {
        ST_WAIT_RESET,
        ST_WAIT_CMD,
        ST_ENGAGED,
        ST_SELECTED,
        ST_ASLEEP
    } csq_state_t;
endpackage

/* File: csq_activity_latch.sv */
`timescale 1ns/100ps
// ============================================================
// Per-channel activity latch
// ============================================================
module csq_activity_latch (
    input wire logic clock,
    input wire logic rstn,
    input wire logic level,
    input wire logic clear,
    output logic latch_q
);
    logic prev_q; // Last seen pin level
    logic primed_q; // Prev holds a real sample
    logic edge_seen; // Either edge on the pin

    // No edge before the first sample, so a high pin at power-up is not an event
    assign edge_seen = primed_q && (level != prev_q);

    // Level history
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prev_q <= 1'b0;
            primed_q <= 1'b0;
        end else begin
            prev_q <= level;
            primed_q <= 1'b1;
        end
    end

    // Sticky latch, the edge beats a simultaneous clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            latch_q <= 1'b0;
        end else if (edge_seen) begin
            latch_q <= 1'b1;
        end else if (clear) begin
            latch_q <= 1'b0;
        end
    end

    // ============================================================
    // Checks
    // ============================================================
    property p_edge_sets;
        @(posedge clock) disable iff (!rstn)
        edge_seen |=> latch_q;
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge did not set latch");

    property p_clear_clears;
        @(posedge clock) disable iff (!rstn)
        clear && !edge_seen |=> !latch_q ##1 (latch_q -> $past(edge_seen));
    endproperty
    a_clear_clears: assert property (p_clear_clears) else $error("clear did not clear latch");
endmodule

/* File: csq_qualifier.sv */
`timescale 1ns/100ps
// Operation
// - Conditional search joined only when condition true
// - Condition comes from status location seven
// - Defaults from OTP location six, erased ones
// - Defaults apply after any command byte; here only after the first, and not if location seven was written before it
// - Resolved pass leaves device selected
// - Activity latch clears at power-up, sets on edge
// - Control byte bit seven clears latches
// - Channel code: none, A, B, A OR B
// - Source sampled when command byte completes
// - Both channels ORed, compared with polarity
// - No channel: polarity zero joins, one ignores
// - Source code: hidden, latch, flop, pin
// - Hidden answers match, conditional search if polarity
// - Hidden sends no presence, except power-up once
// - Hidden with polarity zero skips conditional search
// - Power-on reset ends hidden unless default hidden
// - Polarity picks qualifying source level
// - Missing channel B reads as zero
// - Channel info bit six shows channel B
// - Search bit, complement, master choice
// - Match command selects exact number only
module csq_qualifier (
    input wire logic clock,
    input wire logic rstn,
    input wire logic line_reset,
    input wire logic rom_cmd_valid,
    input wire logic [7:0] rom_cmd,
    input wire logic pass_resolved,
    input wire logic dropped_out,
    input wire logic status_wr,
    input wire logic [2:0] status_addr,
    input wire logic [7:0] status_wdata,
    input wire logic ctrl1_wr,
    input wire logic [7:0] ctrl1_wdata,
    input wire logic io_pin_first,
    input wire logic io_pin_second,
    input wire logic flop_first,
    input wire logic flop_second,
    input wire logic has_channel_b,
    input wire logic supply_present,
    output logic presence_q,
    output logic answer_q,
    output logic search_join_q,
    output logic selected_q,
    output logic line_release_q,
    output logic hidden_q,
    output logic [7:0] status_rdata_q,
    output logic [7:0] channel_info_q
);
    // ============================================================
    // Registers and wires
    // ============================================================
    csq_pkg::csq_state_t state_q; // Link state
    csq_pkg::csq_state_t state_d; // Next link state
    logic [7:0] search_default_byte_q; // OTP power-up defaults
    logic [4:0] search_condition_q; // Live condition bits
    logic loaded_q; // Live bits loaded, from defaults or a write to location seven
    logic first_presence_q; // Power-up presence already given
    logic latch_first; // Activity latch A
    logic latch_second; // Activity latch B
    logic latch_clear; // Software clear of both latches
    logic [4:0] cond_eff; // Condition in force right now
    logic search_polarity_bit;
    logic [1:0] source_sel; // {source_select_high, source_select_low}
    logic [1:0] channel_sel; // {channel_select_high, channel_select_low}
    logic hidden_now; // Hidden by live condition
    logic boot_hidden; // Hidden is the power-up default
    logic pin_b; // Channel B pin, zero when absent
    logic flop_b; // Channel B flop, zero when absent
    logic act_b; // Channel B latch, zero when absent
    logic val_a; // Selected source of channel A
    logic val_b; // Selected source of channel B
    logic sel_val; // Combined channel value
    logic cond_hit; // Qualifies for conditional search
    logic cmd_ok; // Device answers this command
    logic cmd_take; // Command byte accepted this cycle
    logic wr_cond; // Write to location seven
    logic wr_default; // Programming of location six
    logic presence_d; // Presence decision on line reset
    logic [7:0] rdata_d; // Status read mux
    logic [7:0] info_d; // Channel info byte

    // ============================================================
    // Activity latches
    // ============================================================
    assign latch_clear = ctrl1_wr && ctrl1_wdata[csq_pkg::CTRL1_CLR_BIT];

    csq_activity_latch u_latch_first (
        .clock(clock),
        .rstn(rstn),
        .level(io_pin_first),
        .clear(latch_clear),
        .latch_q(latch_first)
    );

    // Latch B watches the masked pin, so while the channel is absent only a strap change fires it
    csq_activity_latch u_latch_second (
        .clock(clock),
        .rstn(rstn),
        .level(pin_b),
        .clear(latch_clear),
        .latch_q(latch_second)
    );

    // ============================================================
    // Condition decode
    // ============================================================
    // Until the first command byte or write to location seven the stored defaults stand in
    assign cond_eff = loaded_q ? search_condition_q : search_default_byte_q[4:0];
    assign search_polarity_bit = cond_eff[csq_pkg::POL_BIT];
    assign source_sel = {cond_eff[csq_pkg::SRC_HI], cond_eff[csq_pkg::SRC_LO]};
    assign channel_sel = {cond_eff[csq_pkg::CH_HI], cond_eff[csq_pkg::CH_LO]};
    assign hidden_now = (source_sel == csq_pkg::SRC_HIDDEN);
    assign boot_hidden = ({search_default_byte_q[csq_pkg::SRC_HI],
                           search_default_byte_q[csq_pkg::SRC_LO]} == csq_pkg::SRC_HIDDEN);

    // Absent second channel is forced low everywhere
    assign pin_b = has_channel_b && io_pin_second;
    assign flop_b = has_channel_b && flop_second;
    assign act_b = has_channel_b && latch_second;

    // Source per channel
    assign val_a = (source_sel == csq_pkg::SRC_LATCH) ? latch_first :
                   (source_sel == csq_pkg::SRC_FLOP) ? flop_first :
                   (source_sel == csq_pkg::SRC_PIN) ? io_pin_first : 1'b0;
    assign val_b = (source_sel == csq_pkg::SRC_LATCH) ? act_b :
                   (source_sel == csq_pkg::SRC_FLOP) ? flop_b :
                   (source_sel == csq_pkg::SRC_PIN) ? pin_b : 1'b0;

    // OR of the selected channels
    assign sel_val = (channel_sel[0] && val_a) || (channel_sel[1] && val_b);

    // Hidden: polarity alone; no channel: polarity zero always; else compare
    assign cond_hit = hidden_now ? search_polarity_bit :
                      (channel_sel == csq_pkg::CH_NONE) ? !search_polarity_bit :
                      (sel_val == search_polarity_bit);

    // Which commands draw an answer
    assign cmd_ok = (rom_cmd == csq_pkg::CMD_MATCH) ? 1'b1 :
                    (rom_cmd == csq_pkg::CMD_COND) ? cond_hit :
                    (rom_cmd == csq_pkg::CMD_SEARCH) ? !hidden_now :
                    (rom_cmd == csq_pkg::CMD_READ) ? !hidden_now :
                    (rom_cmd == csq_pkg::CMD_SKIP) ? !hidden_now : 1'b0;

    // Sampled only on the cycle the command byte completes
    assign cmd_take = rom_cmd_valid && (state_q == csq_pkg::ST_WAIT_CMD);

    assign wr_cond = status_wr && (status_addr == csq_pkg::OFS_COND);
    assign wr_default = status_wr && (status_addr == csq_pkg::OFS_DEFAULT);

    // Hidden stays silent, except the single power-up presence
    assign presence_d = !hidden_now || (boot_hidden && !first_presence_q);

    // ============================================================
    // Link state machine
    // ============================================================
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            csq_pkg::ST_WAIT_RESET: begin
                state_d = csq_pkg::ST_WAIT_RESET;
            end
            csq_pkg::ST_WAIT_CMD: begin
                if (rom_cmd_valid) begin
                    if (!cmd_ok) begin
                        state_d = csq_pkg::ST_ASLEEP;
                    end else if (rom_cmd == csq_pkg::CMD_SKIP) begin
                        state_d = csq_pkg::ST_SELECTED;
                    end else begin
                        state_d = csq_pkg::ST_ENGAGED;
                    end
                end
            end
            csq_pkg::ST_ENGAGED: begin
                if (dropped_out) begin
                    state_d = csq_pkg::ST_ASLEEP;
                end else if (pass_resolved) begin
                    state_d = csq_pkg::ST_SELECTED;
                end
            end
            csq_pkg::ST_SELECTED: begin
                state_d = csq_pkg::ST_SELECTED;
            end
            csq_pkg::ST_ASLEEP: begin
                state_d = csq_pkg::ST_ASLEEP;
            end
        endcase
        // Reset pulse restarts every transaction
        if (line_reset) begin
            state_d = csq_pkg::ST_WAIT_CMD;
        end
    end

    // State register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= csq_pkg::ST_WAIT_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ============================================================
    // Status memory
    // ============================================================
    // OTP bits can only be programmed from one to zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            search_default_byte_q <= csq_pkg::DEFAULT_RESET;
        end else if (wr_default) begin
            search_default_byte_q <= search_default_byte_q & status_wdata;
        end
    end

    // Live condition; power-on reset drops back to defaults
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            search_condition_q <= csq_pkg::COND_RESET;
            loaded_q <= 1'b0;
        end else if (wr_cond) begin
            search_condition_q <= status_wdata[4:0];
            loaded_q <= 1'b1;
        end else if (rom_cmd_valid && !loaded_q) begin
            search_condition_q <= search_default_byte_q[4:0];
            loaded_q <= 1'b1;
        end
    end

    // Power-up presence bookkeeping
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            first_presence_q <= 1'b0;
        end else if (line_reset) begin
            first_presence_q <= 1'b1;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    assign rdata_d = (status_addr == csq_pkg::OFS_COND) ? {3'h0, cond_eff} :
                     (status_addr == csq_pkg::OFS_DEFAULT) ? search_default_byte_q : 8'h00;

    assign info_d = {supply_present, has_channel_b, act_b, latch_first,
                     pin_b, io_pin_first, flop_b, flop_first};

    // Pulses and levels toward the line engine
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            presence_q <= 1'b0;
            answer_q <= 1'b0;
            search_join_q <= 1'b0;
        end else begin
            presence_q <= line_reset && presence_d;
            answer_q <= cmd_take && cmd_ok;
            search_join_q <= cmd_take && (rom_cmd == csq_pkg::CMD_COND) && cond_hit;
        end
    end

    // Registered state views
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            selected_q <= 1'b0;
            line_release_q <= 1'b0;
            hidden_q <= 1'b0;
            status_rdata_q <= 8'h00;
            channel_info_q <= 8'h00;
        end else begin
            selected_q <= (state_d == csq_pkg::ST_SELECTED);
            line_release_q <= (state_d == csq_pkg::ST_ASLEEP);
            hidden_q <= hidden_now;
            status_rdata_q <= rdata_d;
            channel_info_q <= info_d;
        end
    end

    // ============================================================
    // Checks
    // ============================================================
    property p_no_join;
        @(posedge clock) disable iff (!rstn)
        cmd_take && (rom_cmd == csq_pkg::CMD_COND) && !cond_hit && !line_reset
            |=> !search_join_q && line_release_q;
    endproperty
    a_no_join: assert property (p_no_join) else $error("joined without qualifying");

    property p_resolved;
        @(posedge clock) disable iff (!rstn)
        (state_q == csq_pkg::ST_ENGAGED) && pass_resolved && !dropped_out && !line_reset
            |=> selected_q ##1 (selected_q || $past(line_reset));
    endproperty
    a_resolved: assert property (p_resolved) else $error("resolved device not selected");

    property p_defaults;
        @(posedge clock) disable iff (!rstn)
        rom_cmd_valid && !loaded_q && !status_wr
            |=> loaded_q && (search_condition_q == search_default_byte_q[4:0]);
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults not applied");

    property p_hidden_silent;
        @(posedge clock) disable iff (!rstn)
        line_reset && hidden_now && first_presence_q |=> !presence_q;
    endproperty
    a_hidden_silent: assert property (p_hidden_silent) else $error("presence while hidden");

    property p_hidden_match;
        @(posedge clock) disable iff (!rstn)
        cmd_take && hidden_now && (rom_cmd == csq_pkg::CMD_MATCH) |=> answer_q;
    endproperty
    a_hidden_match: assert property (p_hidden_match) else $error("hidden ignored match");

    property p_hidden_pol0;
        @(posedge clock) disable iff (!rstn)
        cmd_take && hidden_now && !search_polarity_bit && (rom_cmd == csq_pkg::CMD_COND)
            |=> !search_join_q;
    endproperty
    a_hidden_pol0: assert property (p_hidden_pol0) else $error("hidden joined at polarity 0");

    property p_none_pol1;
        @(posedge clock) disable iff (!rstn)
        cmd_take && !hidden_now && (channel_sel == csq_pkg::CH_NONE)
            |=> search_join_q == ($past(rom_cmd) == csq_pkg::CMD_COND && !$past(search_polarity_bit));
    endproperty
    a_none_pol1: assert property (p_none_pol1) else $error("no-channel decision wrong");

    property p_asleep;
        @(posedge clock) disable iff (!rstn)
        line_release_q && !line_reset |=> line_release_q && !answer_q ##1 (line_release_q || $past(line_reset));
    endproperty
    a_asleep: assert property (p_asleep) else $error("sleeping device woke without reset");

    property p_no_b;
        @(posedge clock) disable iff (!rstn)
        !has_channel_b |=> !channel_info_q[csq_pkg::INFO_HAS_B] && !channel_info_q[csq_pkg::INFO_PIN_B];
    endproperty
    a_no_b: assert property (p_no_b) else $error("absent channel B not zero");
endmodule

/* File: csq_master_model.sv */
`timescale 1ns/100ps
// ============================================================
// Line master model: reset pulse, one command, search outcome
// ============================================================
module csq_master_model (
    input wire logic clock,
    input wire logic go,
    input wire logic [7:0] cmd,
    input wire logic resolve,
    input wire logic answer_q,
    output logic line_reset,
    output logic rom_cmd_valid,
    output logic [7:0] rom_cmd,
    output logic pass_resolved,
    output logic dropped_out,
    output logic busy
);
    logic [2:0] step_q = 3'h0; // Position in the sequence, 0 is idle
    logic heard_q = 1'b0; // Device answered the last command
    logic is_search; // Command that ends in a search outcome
    // Steps move off the sampling edge; wraps back to idle
    always @(negedge clock) begin
        if (step_q != 3'h0 || go) begin
            step_q <= step_q + 3'h1;
        end
        if (step_q == 3'h3) begin
            heard_q <= answer_q;
        end
    end
    assign is_search = cmd == csq_pkg::CMD_COND || cmd == csq_pkg::CMD_MATCH || cmd == csq_pkg::CMD_SEARCH;
    assign busy = step_q != 3'h0;
    assign line_reset = step_q == 3'h1; // One short reset pulse
    assign rom_cmd_valid = step_q == 3'h3;
    // Idle byte is inverted so a stale value never passes for a command
    assign rom_cmd = rom_cmd_valid ? cmd : ~cmd;
    // Outcome only for a device still in the pass
    assign pass_resolved = step_q == 3'h6 && heard_q && is_search && resolve;
    assign dropped_out = step_q == 3'h6 && heard_q && is_search && !resolve;
endmodule

/* File: conditional_search_qualifier_tb_top.sv */
`timescale 1ns/100ps
// ============================================================
// Bench for the conditional search qualifier
// ============================================================
module conditional_search_qualifier_tb_top;
    logic clock, rstn, status_wr, ctrl1_wr, go, resolve;
    logic io_pin_first, io_pin_second, flop_first, flop_second, has_channel_b, supply_present;
    logic [2:0] status_addr;
    logic [7:0] status_wdata, ctrl1_wdata, rom_cmd, cmd;
    logic line_reset, rom_cmd_valid, pass_resolved, dropped_out, busy;
    logic presence_q, answer_q, search_join_q, selected_q, line_release_q, hidden_q;
    logic [7:0] status_rdata_q, channel_info_q;
    logic [4:0] cond; // Live condition as the bench reckons it
    logic lat_a, lat_b, first, v1; // Latch copies, power-up hidden flag, command seen
    logic [3:0] q[$]; // Notes: {join unchecked, answer, join, release}
    logic [7:0] cmds [8] = '{8'hEC, 8'hEC, 8'hEC, 8'h55, 8'hF0, 8'h33, 8'hCC, 8'hA5};
    int errors = 0, n_tests = 0, n_pres = 0, cycles = 0;
    integer seed;

    csq_qualifier uut (.clock, .rstn, .line_reset, .rom_cmd_valid, .rom_cmd, .pass_resolved,
        .dropped_out, .status_wr, .status_addr, .status_wdata, .ctrl1_wr, .ctrl1_wdata,
        .io_pin_first, .io_pin_second, .flop_first, .flop_second, .has_channel_b, .supply_present,
        .presence_q, .answer_q, .search_join_q, .selected_q, .line_release_q, .hidden_q,
        .status_rdata_q, .channel_info_q);
    csq_master_model master (.clock, .go, .cmd, .resolve, .answer_q, .line_reset, .rom_cmd_valid,
        .rom_cmd, .pass_resolved, .dropped_out, .busy);

    // ============================================================
    // Clock, monitors and hang guard
    // ============================================================
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Presence pulses stand one cycle, counted at the settled edge
    always @(negedge clock) begin
        if (presence_q === 1'b1) begin
            n_pres++;
        end
    end
    // Remember a taken command; a run far past plan is a hang
    always @(posedge clock) begin
        v1 <= rom_cmd_valid;
        cycles++;
        if (cycles == 10000) begin
            errors++;
            give_verdict();
        end
    end
    // Answer to a taken command, judged against the oldest note
    always @(negedge clock) begin
        logic [3:0] e;
        if (v1 === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            chk("answer", 8'(answer_q), 8'(e[2]));
            if (!e[3]) begin
                chk("join", 8'(search_join_q), 8'(e[1]));
            end
            chk("release", 8'(line_release_q), 8'(e[0]));
        end
    end

    // ============================================================
    // Shared tasks
    // ============================================================
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Whether the device should join a conditional search now
    function automatic logic qual();
        logic [1:0] s, ch;
        logic va, vb;
        s = cond[2:1];
        ch = cond[4:3];
        va = s == 2'h1 ? lat_a : s == 2'h2 ? flop_first : io_pin_first;
        vb = has_channel_b & (s == 2'h1 ? lat_b : s == 2'h2 ? flop_second : io_pin_second);
        if (s == csq_pkg::SRC_HIDDEN) begin
            return cond[0];
        end
        if (ch == csq_pkg::CH_NONE) begin
            return !cond[0];
        end
        return ((ch[0] & va) | (ch[1] & vb)) == cond[0];
    endfunction
    task automatic power_on();
        rstn <= 1'b0;
        repeat (3) @(negedge clock);
        rstn <= 1'b1;
        lat_a = 1'b0;
        lat_b = 1'b0;
        cond = 5'h1F;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clock);
        status_wr <= 1'b1;
        status_addr <= a;
        status_wdata <= d;
        @(negedge clock);
        status_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(negedge clock);
        status_addr <= a;
        repeat (2) @(negedge clock);
        chk("status", status_rdata_q, exp);
    endtask
    // Random pins and flops, then a control byte that may clear latches
    task automatic stir();
        logic [7:0] v;
        logic [7:0] ex;
        v = 8'($random(seed));
        @(negedge clock);
        lat_a = lat_a | (v[0] != io_pin_first);
        // Latch B sees the masked pin, so a strap change is an edge too
        lat_b = lat_b | ((v[1] & v[4]) != (io_pin_second & has_channel_b));
        io_pin_first <= v[0];
        io_pin_second <= v[1];
        flop_first <= v[2];
        flop_second <= v[3];
        has_channel_b <= v[4];
        supply_present <= v[5];
        v = 8'($random(seed));
        repeat (2) @(negedge clock);
        ctrl1_wr <= 1'b1;
        ctrl1_wdata <= v;
        @(negedge clock);
        ctrl1_wr <= 1'b0;
        if (v[csq_pkg::CTRL1_CLR_BIT]) begin
            lat_a = 1'b0;
            lat_b = 1'b0;
        end
        repeat (2) @(negedge clock);
        ex = {supply_present, has_channel_b, lat_b & has_channel_b, lat_a,
            io_pin_second & has_channel_b, io_pin_first, flop_second & has_channel_b, flop_first};
        chk("info", channel_info_q, ex);
    endtask
    // One line transaction; the expected answer is noted before it starts
    task automatic run(input logic [7:0] c, input logic r);
        logic hid, j, a;
        int p0;
        hid = cond[2:1] == csq_pkg::SRC_HIDDEN;
        j = qual();
        case (c)
            csq_pkg::CMD_COND: a = j;
            csq_pkg::CMD_MATCH: a = 1'b1;
            csq_pkg::CMD_SEARCH, csq_pkg::CMD_READ, csq_pkg::CMD_SKIP: a = !hid;
            default: a = 1'b0;
        endcase
        q.push_back({c != csq_pkg::CMD_COND, a, j, !a});
        p0 = n_pres;
        cmd <= c;
        resolve <= r;
        @(negedge clock);
        go <= 1'b1;
        @(negedge clock);
        go <= 1'b0;
        @(negedge clock);
        while (busy !== 1'b0) begin
            @(negedge clock);
        end
        chk("presence", 8'(n_pres - p0), 8'(!hid || first));
        first = 1'b0;
        if (c != csq_pkg::CMD_READ) begin
            chk("selected", 8'(selected_q), 8'(a && (c == csq_pkg::CMD_SKIP || r)));
        end
    endtask

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        logic [31:0] v;
        seed = 32'hdcb0b41e;
        {status_wr, ctrl1_wr, go, resolve, io_pin_first, io_pin_second} = 6'h00;
        {flop_first, flop_second, has_channel_b, supply_present} = 4'h0;
        {status_addr, status_wdata, ctrl1_wdata, cmd} = 27'h0;
        first = 1'b0;
        power_on();
        rd(csq_pkg::OFS_DEFAULT, 8'hFF);
        rd(csq_pkg::OFS_COND, 8'h1F);
        rd(3'h5, 8'h00);
        wr(csq_pkg::OFS_DEFAULT, 8'hF9);
        wr(3'h5, 8'h00);
        cond = 5'h19;
        rd(csq_pkg::OFS_COND, 8'h19);
        first = 1'b1;
        run(csq_pkg::CMD_MATCH, 1'b1);
        run(csq_pkg::CMD_COND, 1'b0);
        run(csq_pkg::CMD_SEARCH, 1'b0);
        run(8'hA5, 1'b0);
        wr(csq_pkg::OFS_DEFAULT, 8'hFF);
        rd(csq_pkg::OFS_DEFAULT, 8'hF9);
        rd(csq_pkg::OFS_COND, 8'h19);
        wr(csq_pkg::OFS_COND, 8'h18);
        cond = 5'h18;
        run(csq_pkg::CMD_COND, 1'b1);
        wr(csq_pkg::OFS_COND, 8'h1F);
        cond = 5'h1F;
        rd(csq_pkg::OFS_COND, 8'h1F);
        chk("hidden", 8'(hidden_q), 8'h00);
        $display("test hidden mode done");
        power_on();
        rd(csq_pkg::OFS_DEFAULT, 8'hFF);
        for (int i = 0; i < 60; i++) begin
            stir();
            v = $random(seed);
            cond = v[4:0];
            wr(csq_pkg::OFS_COND, v[7:0]);
            rd(csq_pkg::OFS_COND, {3'h0, cond});
            chk("hidden", 8'(hidden_q), 8'(cond[2:1] == 2'h0));
            run(cmds[v[7:5]], v[8]);
        end
        $display("test random conditions done");
        give_verdict();
    end
endmodule
